// File: pzg_map.svh
// Port zero register map, field layout and reset values.
// Assumes a 32-bit classic Wishbone slave, one register per aligned word.
// How it works
// RULE1: Normal data read returns pin levels
// RULE2: Read-modify-write data read returns latch value
// RULE3: Control registers read back last written value (code returns stop_mode_i, not the written bit, in standby bit 1)
// RULE4: Software never writes unused or disabled addresses
// RULE5: Unused address reads complete, data undefined
// RULE6: Reset clears the data latch
// RULE7: Reset clears analog disable, pins analog
// RULE8: Port has latch, direction, pull-up, analog-disable
// RULE9: Pins 0,1,3,4 feed irq, converter, comparator
// RULE10: Direction one drives latch, zero is input
// RULE11: Digital input only when analog-disable bit set
// RULE12: Pull-up on when bit set, off driving low
// RULE13: Standby float: pins float, inputs forced low (code leaves inputs of pins with irq_en_i set passing the pad level)
`ifndef PZG_MAP_SVH
`define PZG_MAP_SVH

// Register byte offsets
`define PZG_OFS_DATA     8'h00
`define PZG_OFS_DIR      8'h04
`define PZG_OFS_PULLUP   8'h08
`define PZG_OFS_ADIS     8'h0C
`define PZG_OFS_STBY     8'h10

// Reset values
`define PZG_RST_DATA     8'h00
`define PZG_RST_DIR      8'h00
`define PZG_RST_PULLUP   8'h00
`define PZG_RST_ADIS     8'h00
`define PZG_RST_STBY     2'h0

// Standby control fields
`define PZG_STBY_FLOAT   0
`define PZG_STBY_ENTER   1

// Value returned from unused addresses
`define PZG_UNUSED_DATA  32'h0000_0000

`endif

// File: pzg_pkg.sv
// Types shared by the port zero design.
// Assumes the register map header is compiled alongside.
package pzg_pkg;

  // Wishbone slave answer phase
  typedef enum logic {
    PZG_IDLE,
    PZG_ACK
  } pzg_bus_e;

  typedef logic [7:0] pzg_byte_t;

endpackage : pzg_pkg

// File: pzg_pin.sv
// One port zero pin: drive, pull-up, input gating and standby float.
// Assumes pin input already synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none

module pzg_pin
  import pzg_pkg::*;
(
  // Control bits
  input  wire logic latch_i,
  input  wire logic dir_i,
  input  wire logic pullup_i,
  input  wire logic adis_i,
  input  wire logic analog_ok_i,
  input  wire logic float_i,
  input  wire logic irq_en_i,
  // Pad side
  input  wire logic pad_i,
  // Results
  output logic      out_o,
  output logic      oe_o,
  output logic      pu_o,
  output logic      dig_o,
  output logic      irq_o
);

  logic gate_off;

  // Pin drive and pull-up control
  always_comb
  begin
    gate_off = float_i & ~irq_en_i;
    oe_o     = dir_i & ~float_i;                                  // RULE10 RULE13
    out_o    = latch_i;                                           // RULE10
    pu_o     = pullup_i & ~(oe_o & ~latch_i) & ~float_i;          // RULE12
    dig_o    = (adis_i | ~analog_ok_i) & ~gate_off & pad_i;       // RULE11 RULE13
    irq_o    = float_i ? (irq_en_i & pad_i) : pad_i;              // RULE13
  end

endmodule : pzg_pin

`default_nettype wire

// File: pzg_port.sv
// Port zero general I/O top: Wishbone registers and eight pins.
// Assumes inputs synchronous to clk_i, CPU flags rmw_i during RMW reads.
`timescale 1ns/1ps
`default_nettype none
`include "pzg_map.svh"

module pzg_port
  import pzg_pkg::*;
#(
  parameter int          WIDTH      = 8,
  parameter logic [7:0]  ANALOG_PIN = 8'hFF
)
(
  // Clock, reset, enable
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // Wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  input  wire logic              rmw_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // Standby and interrupt enables
  input  wire logic              stop_mode_i,
  input  wire logic [WIDTH-1:0]  irq_en_i,
  // Pads
  input  wire logic [WIDTH-1:0]  pad_i,
  output logic      [WIDTH-1:0]  pad_o,
  output logic      [WIDTH-1:0]  pad_oe_o,
  output logic      [WIDTH-1:0]  pullup_o,
  // Peripheral feeds
  output logic      [WIDTH-1:0]  port_in_o,
  output logic      [WIDTH-1:0]  ext_irq_o,
  output logic      [WIDTH-1:0]  analog_sel_o,
  output logic                   comparator_a_pos_sel_o,
  output logic                   comparator_a_neg_sel_o,
  output logic                   comparator_b_pos_sel_o,
  output logic                   comparator_b_neg_sel_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  pzg_bus_e         bus_st,   next_bus_st;
  logic [WIDTH-1:0] port_zero_data_latch,    next_port_zero_data_latch;
  logic [WIDTH-1:0] port_zero_direction,     next_port_zero_direction;
  logic [WIDTH-1:0] port_zero_pullup_enable, next_port_zero_pullup_enable;
  logic [WIDTH-1:0] analog_input_disable_low, next_analog_input_disable_low;
  logic [1:0]       stby,     next_stby;
  logic [31:0]      rdata,    next_rdata;

  logic [WIDTH-1:0] c_out, c_oe, c_pu, c_dig, c_irq;
  logic             float_act;
  logic             req;

  // Byte lane 0 merge
  function automatic logic [WIDTH-1:0] merge(input logic [WIDTH-1:0] old_v);
    merge = sel_i[0] ? dat_i[WIDTH-1:0] : old_v;
  endfunction : merge

  // Standby float active when enabled and entered
  assign float_act = stby[`PZG_STBY_FLOAT] & stop_mode_i;                // RULE13
  assign req       = cyc_i & stb_i & (bus_st == PZG_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin logic

  // Eight pin slices
  for (genvar g = 0; g < WIDTH; g++)
  begin : g_pin                                                          // RULE8
    pzg_pin u_pin (
      .latch_i     (port_zero_data_latch[g]),
      .dir_i       (port_zero_direction[g]),
      .pullup_i    (port_zero_pullup_enable[g]),
      .adis_i      (analog_input_disable_low[g]),
      .analog_ok_i (ANALOG_PIN[g]),
      .float_i     (float_act),
      .irq_en_i    (irq_en_i[g]),
      .pad_i       (pad_i[g]),
      .out_o       (c_out[g]),
      .oe_o        (c_oe[g]),
      .pu_o        (c_pu[g]),
      .dig_o       (c_dig[g]),
      .irq_o       (c_irq[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus and register next state

  always_comb
  begin
    next_bus_st                   = PZG_IDLE;
    next_port_zero_data_latch     = port_zero_data_latch;
    next_port_zero_direction      = port_zero_direction;
    next_port_zero_pullup_enable  = port_zero_pullup_enable;
    next_analog_input_disable_low = analog_input_disable_low;
    next_stby                     = stby;
    next_rdata                    = rdata;
    if (req)
    begin
      next_bus_st = PZG_ACK;
      next_rdata  = `PZG_UNUSED_DATA;                                    // RULE5
      if (we_i)
      begin
        unique case (adr_i)
          `PZG_OFS_DATA:   next_port_zero_data_latch = merge(port_zero_data_latch); // RULE10
          `PZG_OFS_DIR:    next_port_zero_direction = merge(port_zero_direction);
          `PZG_OFS_PULLUP: next_port_zero_pullup_enable = merge(port_zero_pullup_enable);
          `PZG_OFS_ADIS:   next_analog_input_disable_low = merge(analog_input_disable_low);
          `PZG_OFS_STBY:   next_stby = sel_i[0] ? dat_i[1:0] : stby;
          default:         next_stby = stby;                             // RULE4
        endcase
      end
      else
      begin
        unique case (adr_i)
          `PZG_OFS_DATA:
            next_rdata[WIDTH-1:0] = rmw_i ? port_zero_data_latch         // RULE2
                                          : pad_i;                       // RULE1
          `PZG_OFS_DIR:    next_rdata[WIDTH-1:0] = port_zero_direction;      // RULE3
          `PZG_OFS_PULLUP: next_rdata[WIDTH-1:0] = port_zero_pullup_enable;  // RULE3
          `PZG_OFS_ADIS:   next_rdata[WIDTH-1:0] = analog_input_disable_low; // RULE3
          `PZG_OFS_STBY:   next_rdata[1:0] = {stop_mode_i, stby[`PZG_STBY_FLOAT]};
          default:         next_rdata = `PZG_UNUSED_DATA;                // RULE5
        endcase
      end
    end
  end

  // Register update
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bus_st                   <= PZG_IDLE;
      port_zero_data_latch     <= `PZG_RST_DATA;                         // RULE6
      port_zero_direction      <= `PZG_RST_DIR;
      port_zero_pullup_enable  <= `PZG_RST_PULLUP;
      analog_input_disable_low <= `PZG_RST_ADIS;                         // RULE7
      stby                     <= `PZG_RST_STBY;
      rdata                    <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      bus_st                   <= next_bus_st;
      port_zero_data_latch     <= next_port_zero_data_latch;
      port_zero_direction      <= next_port_zero_direction;
      port_zero_pullup_enable  <= next_port_zero_pullup_enable;
      analog_input_disable_low <= next_analog_input_disable_low;
      stby                     <= next_stby;
      rdata                    <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dat_o                  <= 32'h0000_0000;
      ack_o                  <= 1'b0;
      pad_o                  <= '0;
      pad_oe_o               <= '0;
      pullup_o               <= '0;
      port_in_o              <= '0;
      ext_irq_o              <= '0;
      analog_sel_o           <= '0;
      comparator_a_pos_sel_o <= 1'b0;
      comparator_a_neg_sel_o <= 1'b0;
      comparator_b_pos_sel_o <= 1'b0;
      comparator_b_neg_sel_o <= 1'b0;
    end
    else if (ce_i)
    begin
      dat_o        <= next_rdata;
      ack_o        <= (next_bus_st == PZG_ACK);
      pad_o        <= c_out;                                             // RULE10
      pad_oe_o     <= c_oe;                                              // RULE10
      pullup_o     <= c_pu;                                              // RULE12
      port_in_o    <= c_dig;                                             // RULE11
      ext_irq_o    <= c_irq;                                             // RULE9
      analog_sel_o <= ANALOG_PIN & ~analog_input_disable_low;            // RULE11
      // Comparator inputs on pins 0,1,3,4 while in analog mode
      comparator_a_pos_sel_o <= ~analog_input_disable_low[0];            // RULE9
      comparator_a_neg_sel_o <= ~analog_input_disable_low[1];            // RULE9
      comparator_b_pos_sel_o <= ~analog_input_disable_low[3];            // RULE9
      comparator_b_neg_sel_o <= ~analog_input_disable_low[4];            // RULE9
    end
  end

endmodule : pzg_port

`default_nettype wire

// File: pzg_port_properties.sv
// Checker for port zero bus handshake and pin outputs.
// Assumes binding to pzg_port with the default width of eight pins.
`timescale 1ns/1ps
`default_nettype none
module pzg_port_chk
(
  // Clock and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic        rmw_i,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // Pins and feeds
  input wire logic [7:0]  pad_i,
  input wire logic [7:0]  pad_o,
  input wire logic [7:0]  pad_oe_o,
  input wire logic [7:0]  pullup_o,
  input wire logic [7:0]  port_in_o,
  input wire logic [7:0]  ext_irq_o,
  input wire logic [7:0]  analog_sel_o,
  input wire logic        comparator_a_pos_sel_o,
  input wire logic        comparator_a_neg_sel_o,
  input wire logic        comparator_b_pos_sel_o,
  input wire logic        comparator_b_neg_sel_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request taken, and read answer
  sequence s_take; cyc_i && stb_i && ce_i && !ack_o; endsequence
  sequence s_read; ack_o && !we_i; endsequence
  chk_ack_after:
    assert property (s_take |=> ack_o) else $error("ack missing after request");
  chk_ack_once:
    assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  chk_read_pins:
    assert property (s_read ##0 (adr_i == 8'h00 && !rmw_i) |-> dat_o == {24'h0, $past(pad_i)})
      else $error("data read not pin level");
  chk_read_unused:
    assert property (s_read ##0 adr_i == 8'h40 |-> dat_o == 32'h0) else $error("unused read");
  chk_pullup_low:
    assert property ((pullup_o & pad_oe_o & ~pad_o) == 8'h00) else $error("pull-up on low pin");
  chk_input_gate:
    assert property ($past(ce_i) |-> (port_in_o & ~$past(pad_i)) == 8'h00)
      else $error("input not from pin");
  chk_irq_feed:
    assert property ($past(ce_i) |-> (ext_irq_o & ~$past(pad_i)) == 8'h00)
      else $error("irq feed not from pin");
  chk_comp_map:
    assert property ({comparator_a_pos_sel_o, comparator_a_neg_sel_o, comparator_b_pos_sel_o,
      comparator_b_neg_sel_o} == {analog_sel_o[0], analog_sel_o[1], analog_sel_o[3],
      analog_sel_o[4]}) else $error("comparator pin map");
endmodule : pzg_port_chk
bind pzg_port pzg_port_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .rmw_i(rmw_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .pad_i(pad_i), .pad_o(pad_o), .pad_oe_o(pad_oe_o), .pullup_o(pullup_o),
  .port_in_o(port_in_o), .ext_irq_o(ext_irq_o), .analog_sel_o(analog_sel_o),
  .comparator_a_pos_sel_o(comparator_a_pos_sel_o),
  .comparator_a_neg_sel_o(comparator_a_neg_sel_o),
  .comparator_b_pos_sel_o(comparator_b_pos_sel_o),
  .comparator_b_neg_sel_o(comparator_b_neg_sel_o));
`default_nettype wire

// File: pzg_board.sv
// Board model: external drivers and pull-ups seen on port zero pads.
// Assumes pad drive outputs change just after the clock edge.
`timescale 1ns/1ps
`default_nettype none
module pzg_board
(
  // Clock
  input  wire logic       clk_i,
  // Device drive
  input  wire logic [7:0] out_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] pu_i,
  // Board drive
  input  wire logic [7:0] drv_en_i,
  input  wire logic [7:0] lvl_i,
  // Resolved level
  output logic      [7:0] pad_o
);
  logic [7:0] last;
  // Last level, so a floating pin drifts
  always_ff @(posedge clk_i) last <= pad_o;
  // Device drive wins, then board, then pull-up
  always_comb
    for (int i = 0; i < 8; i++)
      pad_o[i] = oe_i[i] ? out_i[i] : drv_en_i[i] ? lvl_i[i] : pu_i[i] ? 1'b1 : ~last[i];
endmodule : pzg_board
`default_nettype wire

// File: tb_pzg_port.sv
// Self-checking bench for port zero: registers, pins, standby float.
// Assumes pzg_port, the board model and the bound checker are compiled.
`timescale 1ns/1ps
`default_nettype none
module tb_pzg_port;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, rmw_i, stop_mode_i, ack_o;
  logic [7:0]  adr_i, irq_en_i, pad_i, pad_o, pad_oe_o, pullup_o, port_in_o, ext_irq_o, asel;
  logic [7:0]  drv_en, lvl, r, dir, ad;
  logic        ce;
  logic [31:0] dat_i, dat_o;
  logic [31:0] q[$];
  int          num_errors, checks, seed, n;
  pzg_port dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .rmw_i(rmw_i), .dat_o(dat_o),
    .ack_o(ack_o), .stop_mode_i(stop_mode_i), .irq_en_i(irq_en_i), .pad_i(pad_i),
    .pad_o(pad_o), .pad_oe_o(pad_oe_o), .pullup_o(pullup_o), .port_in_o(port_in_o),
    .ext_irq_o(ext_irq_o), .analog_sel_o(asel), .comparator_a_pos_sel_o(),
    .comparator_a_neg_sel_o(), .comparator_b_pos_sel_o(), .comparator_b_neg_sel_o());
  pzg_board board (.clk_i(clk_i), .out_i(pad_o), .oe_i(pad_oe_o), .pu_i(pullup_o),
    .drv_en_i(drv_en), .lvl_i(lvl), .pad_o(pad_i));
  // Clock, 4 ns period
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Compare one result
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  // One classic Wishbone cycle; reads note their expectation
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    input logic [7:0] e, input logic m);
    int k;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, rmw_i} <= {2'b11, w, m};
    adr_i <= a;
    dat_i <= {24'h0, d};
    if (!w)
      q.push_back({24'h0, e});
    for (k = 0; k < 20 && ack_o !== 1'b1; k++)
      @(posedge clk_i);
    if (k == 20)
    begin
      num_errors++;
      summarize();
    end
    {cyc_i, stb_i, we_i, rmw_i} <= 4'h0;
  endtask : wb
  // Compare each read answer with the oldest note
  always @(posedge clk_i)
    if (ack_o === 1'b1 && we_i === 1'b0)
      cmp(dat_o, q.pop_front());
  // Main sequence
  initial
  begin
    {cyc_i, stb_i, we_i, rmw_i, stop_mode_i} = 5'h0;
    {adr_i, irq_en_i, dat_i} = 48'h0;
    drv_en = 8'hFF;
    lvl = 8'hA5;
    ce = 1'b1;
    num_errors = 0;
    checks = 0;
    seed = 40620;
    rst_i = 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, 8'h04, 8'h00, 8'h00, 0);
    wb(0, 8'h08, 8'h00, 8'h00, 0);
    wb(0, 8'h0C, 8'h00, 8'h00, 0);
    wb(0, 8'h00, 8'h00, 8'h00, 1);
    wb(0, 8'h00, 8'h00, lvl, 0);
    cmp({24'h0, asel}, 32'hFF);
    $display("test reset done");
    // Only mapped offsets are written
    for (n = 0; n < 12; n++)
    begin
      r = 8'($random(seed));
      wb(1, 8'h04 + 8'(n % 3) * 8'h04, r, 8'h00, 0);
      wb(0, 8'h04 + 8'(n % 3) * 8'h04, 8'h00, r, 0);
    end
    $display("test readback done");
    dir = 8'($random(seed));
    r = 8'($random(seed));
    wb(1, 8'h04, dir, 8'h00, 0);
    wb(1, 8'h00, r, 8'h00, 0);
    wb(0, 8'h00, 8'h00, r, 1);
    wb(0, 8'h00, 8'h00, (r & dir) | (lvl & ~dir), 0);
    cmp({24'h0, pad_oe_o}, {24'h0, dir});
    wb(1, 8'h08, 8'hFF, 8'h00, 0);
    drv_en <= 8'h00;
    wb(0, 8'h00, 8'h00, (r & dir) | ~dir, 0);
    cmp({24'h0, pullup_o}, {24'h0, ~(dir & ~r)});
    drv_en <= 8'hFF;
    $display("test drive done");
    ad = 8'($random(seed));
    wb(1, 8'h0C, ad, 8'h00, 0);
    repeat (2) @(posedge clk_i);
    cmp({24'h0, port_in_o}, {24'h0, ((r & dir) | (lvl & ~dir)) & ad});
    cmp({24'h0, asel}, {24'h0, ~ad});
    cmp({24'h0, ext_irq_o}, {24'h0, (r & dir) | (lvl & ~dir)});
    // Clock enable low freezes the input feed while the board level flips
    ce <= 1'b0;
    lvl <= ~lvl;
    repeat (3) @(posedge clk_i);
    cmp({24'h0, port_in_o}, {24'h0, ((r & dir) | (~lvl & ~dir)) & ad});
    ce <= 1'b1;
    lvl <= ~lvl;
    repeat (2) @(posedge clk_i);
    cmp({24'h0, port_in_o}, {24'h0, ((r & dir) | (lvl & ~dir)) & ad});
    wb(0, 8'h40, 8'h00, 8'h00, 0);
    $display("test analog done");
    wb(1, 8'h10, 8'h01, 8'h00, 0);
    irq_en_i <= 8'h0F;
    stop_mode_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    cmp({24'h0, pad_oe_o | pullup_o}, 32'h0);
    cmp({24'h0, port_in_o}, {24'h0, lvl & ad & 8'h0F});
    cmp({24'h0, ext_irq_o}, {24'h0, lvl & 8'h0F});
    wb(0, 8'h10, 8'h00, 8'h03, 0);
    stop_mode_i <= 1'b0;
    $display("test float done");
    summarize();
  end
endmodule : tb_pzg_port
`default_nettype wire
